/* File: core/haptic_driver_control.sv */
// haptic driver control: fault lock, timeout, four drive modes, pattern memory
// assumes synchronous register strobes, analog fault flags and pins synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "haptic_consts.svh"

// Overview of operation
// - abort vibration exceeding timeout, one-second steps
// - zero timeout code disables the abort
// - overcurrent while active and enabled locks driver
// - overtemperature shuts driver down unless disabled
// - any fault aborts and locks until unlock
// - supply, overcurrent, thermal, timeout are faults
// - unlock write clears fault, self-clears
// - four modes; nonzero mode enables driver
// - pwm duty maps to signed amplitude, deadzone
// - idle pwm input nulls output
// - realtime level: seven-bit amplitude, sign bit
// - realtime mode drives latest written level
// - trigger edge runs overdrive, active, brake
// - held trigger extends active until fall
// - 256x24 memory, playback from start pointer
// - data registers read bytes at pointer
// - sample packing across high, mid, low
// - control code: last, next, interpolate, repeat
// - hold and gap count five-millisecond steps
// - repeat count zero to fifteen
module haptic_driver_control #(
    parameter int unsigned TMO_UNIT_CYC = `HD_CLK_HZ / 1000 * `HD_TMO_UNIT_MS,
    parameter int unsigned STEP_CYC     = `HD_CLK_HZ / 1000 * `HD_STEP_MS,
    parameter int unsigned IDLE_CYC     = `HD_CLK_HZ / 1000000 * `HD_PWM_IDLE_US,
    parameter int unsigned MEM_DEPTH    = 256
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       multipurpose_pin,
    input  wire logic       supply_below_cutoff,
    input  wire logic       positive_leg_overcurrent_flag,
    input  wire logic       negative_leg_overcurrent_flag,
    input  wire logic       overtemp_flag,
    output logic            driver_enable,
    output logic      [6:0] drive_amplitude,
    output logic            drive_negative,
    output logic            fault_locked
);
    localparam int unsigned PWM_W = 16;

    haptic_pkg::state_t s_reg, s_next;
    logic [23:0] mem_reg [MEM_DEPTH];
    logic        rst_meta, rst_sync;
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (!rst_sync);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    logic        active, trig_src, trig_rise, mem_wr;
    logic [7:0]  sel_level;
    logic [23:0] mem_q;
    haptic_pkg::sample_t mem_smp;
    haptic_pkg::fault_t  det;
    logic [PWM_W+10:0]   hi_scaled;

    assign mem_q   = mem_reg[s_reg.mem_ptr];
    assign mem_smp = haptic_pkg::sample_t'(mem_reg[s_reg.ptr]);
    // write commits on the low byte so the three bytes land together
    assign mem_wr  = reg_wr && s_reg.mem_en && reg_addr == `HD_OFS_MEM_LOW;

    always_ff @(posedge clk) begin
        if (mem_wr) begin
            mem_reg[s_reg.mem_ptr] <= {s_reg.wbuf[23:8], reg_wdata};
        end
    end

    always_comb begin
        s_next    = s_reg;
        active    = s_reg.drv_en;
        trig_src  = (s_reg.mode == `HD_MODE_RAM || s_reg.mode == `HD_MODE_EDGE_TRIGGER_MODE)
                    ? (multipurpose_pin | s_reg.sw_trig) : 1'b0;
        trig_rise = trig_src && !s_reg.trig_d;
        sel_level = 8'h00;
        hi_scaled = '0;
        det       = '0;

        // faults and lock
        det.fault_supply      = supply_below_cutoff && s_reg.mode != `HD_MODE_RESET;
        det.fault_overcurrent = active && !s_reg.oc_dis &&
            (positive_leg_overcurrent_flag || negative_leg_overcurrent_flag);
        det.fault_thermal     = !s_reg.th_dis && overtemp_flag;
        det.fault_timeout     = active && s_reg.tmo != 6'h00 &&
                                s_reg.vib_sec >= s_reg.tmo;

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `HD_OFS_CTRL: begin
                    s_next.clk_en  = reg_wdata[`HD_CTRL_CLKEN_BIT];
                    s_next.oc_dis  = reg_wdata[`HD_CTRL_OCDIS_BIT];
                    s_next.th_dis  = reg_wdata[`HD_CTRL_THDIS_BIT];
                    s_next.sw_trig = reg_wdata[`HD_CTRL_SWTRIG_BIT];
                    s_next.mem_en  = reg_wdata[`HD_CTRL_MEMEN_BIT];
                    if (reg_wdata[`HD_CTRL_UNLOCK_BIT]) begin
                        s_next.locked = 1'b0;
                        s_next.faults = '0;
                    end
                end
                `HD_OFS_MODE:      s_next.mode      = reg_wdata[4:0];
                `HD_OFS_TMO:       s_next.tmo       = reg_wdata[5:0];
                `HD_OFS_RT_LEVEL:  s_next.rt_level  = reg_wdata;
                `HD_OFS_OD_LEVEL:  s_next.od_level  = reg_wdata;
                `HD_OFS_ACT_LEVEL: s_next.act_level = reg_wdata;
                `HD_OFS_BRK_LEVEL: s_next.brk_level = reg_wdata;
                `HD_OFS_OD_TIME:   s_next.od_time   = reg_wdata;
                `HD_OFS_ACT_TIME:  s_next.act_time  = reg_wdata;
                `HD_OFS_BRK_TIME:  s_next.brk_time  = reg_wdata;
                `HD_OFS_PAT_START: s_next.pat_start = reg_wdata;
                `HD_OFS_MEM_PTR:   s_next.mem_ptr   = reg_wdata;
                `HD_OFS_MEM_HIGH:  s_next.wbuf[23:16] = reg_wdata;
                `HD_OFS_MEM_MID:   s_next.wbuf[15:8]  = reg_wdata;
                default: ;
            endcase
        end
        // a fault arriving with the unlock write still wins
        if (det != '0) begin
            s_next.locked = 1'b1;
            s_next.faults = s_reg.faults | det;
        end

        // register reads; data bytes come straight from memory
        if (reg_rd) begin
            unique case (reg_addr)
                `HD_OFS_CTRL: s_next.rdata = {2'b00, s_reg.mem_en, s_reg.sw_trig, 1'b0,
                                              s_reg.th_dis, s_reg.oc_dis, s_reg.clk_en};
                `HD_OFS_MODE:      s_next.rdata = {3'b000, s_reg.mode};
                `HD_OFS_TMO:       s_next.rdata = {2'b00, s_reg.tmo};
                `HD_OFS_STATUS:    s_next.rdata = {3'b000, s_reg.locked, s_reg.faults};
                `HD_OFS_RT_LEVEL:  s_next.rdata = s_reg.rt_level;
                `HD_OFS_OD_LEVEL:  s_next.rdata = s_reg.od_level;
                `HD_OFS_ACT_LEVEL: s_next.rdata = s_reg.act_level;
                `HD_OFS_BRK_LEVEL: s_next.rdata = s_reg.brk_level;
                `HD_OFS_OD_TIME:   s_next.rdata = s_reg.od_time;
                `HD_OFS_ACT_TIME:  s_next.rdata = s_reg.act_time;
                `HD_OFS_BRK_TIME:  s_next.rdata = s_reg.brk_time;
                `HD_OFS_PAT_START: s_next.rdata = s_reg.pat_start;
                `HD_OFS_MEM_PTR:   s_next.rdata = s_reg.mem_ptr;
                `HD_OFS_MEM_HIGH:  s_next.rdata = mem_q[23:16];
                `HD_OFS_MEM_MID:   s_next.rdata = mem_q[15:8];
                `HD_OFS_MEM_LOW:   s_next.rdata = mem_q[7:0];
                default:           s_next.rdata = 8'h00;
            endcase
        end

        // pwm duty measurement; idle input restarts nothing
        s_next.pin_d = multipurpose_pin;
        if (multipurpose_pin != s_reg.pin_d) begin
            s_next.idle_cnt = '0;
        end else if (s_reg.idle_cnt < PWM_W'(IDLE_CYC)) begin
            s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
        end else begin
            s_next.pwm_valid = 1'b0;
        end
        if (multipurpose_pin && !s_reg.pin_d) begin
            // period closes on rising edge; per-mille duty decides the level
            hi_scaled = (PWM_W+11)'(s_reg.hi_cnt) * 11'd1000;
            s_next.pwm_valid = s_reg.per_cnt != '0;
            if (hi_scaled >= (PWM_W+11)'(s_reg.per_cnt) * `HD_DUTY_HI_PERMIL) begin
                s_next.pwm_level = {1'b0, 7'((((PWM_W+11)'(s_reg.hi_cnt) * 200 -
                    (PWM_W+11)'(s_reg.per_cnt) * 105) * 127) /
                    ((PWM_W+11)'(s_reg.per_cnt) * 95))};
            end else if (hi_scaled <= (PWM_W+11)'(s_reg.per_cnt) * `HD_DUTY_LO_PERMIL) begin
                s_next.pwm_level = {1'b1, 7'((((PWM_W+11)'(s_reg.per_cnt) * 95 -
                    (PWM_W+11)'(s_reg.hi_cnt) * 200) * 127) /
                    ((PWM_W+11)'(s_reg.per_cnt) * 95))};
            end else begin
                s_next.pwm_level = 8'h00;
            end
            s_next.hi_cnt  = PWM_W'(1);
            s_next.per_cnt = PWM_W'(1);
        end else begin
            s_next.per_cnt = s_reg.per_cnt + 1'b1;
            s_next.hi_cnt  = s_reg.hi_cnt + PWM_W'(multipurpose_pin);
        end

        // sequencer for triggered and stored patterns
        s_next.trig_d = trig_src;
        s_next.tcnt   = s_reg.tcnt + 1;
        unique case (s_reg.st)
            haptic_pkg::SEQ_IDLE: begin
                s_next.tcnt = '0;
                if (trig_rise && s_reg.mode == `HD_MODE_EDGE_TRIGGER_MODE) begin
                    s_next.st = haptic_pkg::SEQ_OVERDRIVE;
                end else if (trig_rise && s_reg.mode == `HD_MODE_RAM) begin
                    s_next.ptr  = s_reg.pat_start;
                    s_next.prep = 4'h0;
                    s_next.st   = haptic_pkg::SEQ_FETCH;
                end
            end
            haptic_pkg::SEQ_OVERDRIVE: if (s_reg.tcnt >= 32'(s_reg.od_time) * STEP_CYC) begin
                s_next.st = haptic_pkg::SEQ_ACTIVE;
                s_next.tcnt = '0;
            end
            haptic_pkg::SEQ_ACTIVE: if (s_reg.tcnt >= 32'(s_reg.act_time) * STEP_CYC &&
                                        !trig_src) begin
                s_next.st = haptic_pkg::SEQ_BRAKE;
                s_next.tcnt = '0;
            end
            haptic_pkg::SEQ_BRAKE: if (s_reg.tcnt >= 32'(s_reg.brk_time) * STEP_CYC) begin
                s_next.st = haptic_pkg::SEQ_IDLE;
            end
            haptic_pkg::SEQ_FETCH: begin
                s_next.smp  = mem_smp;
                s_next.rep  = mem_smp.repeat_count;
                s_next.tcnt = '0;
                s_next.st   = haptic_pkg::SEQ_HOLD;
            end
            haptic_pkg::SEQ_HOLD: if (s_reg.tcnt >= 32'(s_reg.smp.hold) * STEP_CYC) begin
                s_next.st = haptic_pkg::SEQ_GAP;
                s_next.tcnt = '0;
            end
            haptic_pkg::SEQ_GAP: if (s_reg.tcnt >= 32'(s_reg.smp.gap) * STEP_CYC) begin
                s_next.tcnt = '0;
                if (s_reg.smp.sample_control != 2'b11 && s_reg.rep != 4'h0) begin
                    s_next.rep = s_reg.rep - 1'b1;
                    s_next.st  = haptic_pkg::SEQ_HOLD;
                end else if (s_reg.smp.sample_control == 2'b11 &&
                             s_reg.prep != s_reg.smp.repeat_count) begin
                    s_next.prep = s_reg.prep + 1'b1;
                    s_next.ptr  = s_reg.pat_start;
                    s_next.st   = haptic_pkg::SEQ_FETCH;
                end else if (s_reg.smp.sample_control[0] ^ s_reg.smp.sample_control[1]) begin
                    s_next.ptr = s_reg.ptr + 1'b1;
                    s_next.st  = haptic_pkg::SEQ_FETCH;
                end else begin
                    s_next.st = haptic_pkg::SEQ_IDLE;
                end
            end
            default: s_next.st = haptic_pkg::SEQ_IDLE;
        endcase

        // output selection; interpolation steps as plain hold
        unique case (s_reg.mode)
            `HD_MODE_PIN_PULSE_WIDTH_MODE: sel_level = s_reg.pwm_valid ? s_reg.pwm_level : 8'h00;
            `HD_MODE_RT:   sel_level = s_reg.rt_level;
            `HD_MODE_EDGE_TRIGGER_MODE, `HD_MODE_RAM: begin
                unique case (s_reg.st)
                    haptic_pkg::SEQ_OVERDRIVE: sel_level = s_reg.od_level;
                    haptic_pkg::SEQ_ACTIVE:    sel_level = s_reg.act_level;
                    haptic_pkg::SEQ_BRAKE:     sel_level = s_reg.brk_level;
                    haptic_pkg::SEQ_HOLD:      sel_level = {s_reg.smp.sample_polarity,
                                                            s_reg.smp.amp};
                    default:                   sel_level = 8'h00;
                endcase
            end
            default: sel_level = 8'h00;
        endcase

        // enable follows mode; lock aborts everything
        s_next.drv_en    = s_reg.mode != `HD_MODE_RESET && s_reg.clk_en && !s_next.locked;
        s_next.drv_level = s_next.drv_en ? sel_level : 8'h00;
        if (s_next.locked || s_reg.mode != `HD_MODE_EDGE_TRIGGER_MODE && s_reg.mode != `HD_MODE_RAM) begin
            s_next.st = haptic_pkg::SEQ_IDLE;
        end
        // vibration time: counts while nonzero drive, seconds saturate
        if (s_reg.drv_en && s_reg.drv_level[6:0] != 7'h00) begin
            if (s_reg.vib_cnt >= TMO_UNIT_CYC - 1) begin
                s_next.vib_cnt = '0;
                s_next.vib_sec = (s_reg.vib_sec == 6'h3f) ? s_reg.vib_sec : s_reg.vib_sec + 1'b1;
            end else begin
                s_next.vib_cnt = s_reg.vib_cnt + 1;
            end
        end else begin
            s_next.vib_cnt = '0;
            s_next.vib_sec = 6'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata       = s_reg.rdata;
    assign driver_enable   = s_reg.drv_en;
    assign drive_amplitude = s_reg.drv_level[6:0];
    assign drive_negative  = s_reg.drv_level[7];
    assign fault_locked    = s_reg.locked;

    property p_fault_locks;
        (overtemp_flag && !s_reg.th_dis) |=> fault_locked && !driver_enable;
    endproperty
    a_fault_locks: assert property (p_fault_locks) else $error("thermal not locked");
    property p_oc_locks;
        (driver_enable && !s_reg.oc_dis && positive_leg_overcurrent_flag) |=> fault_locked;
    endproperty
    a_oc_locks: assert property (p_oc_locks) else $error("overcurrent not locked");
    property p_locked_null;
        fault_locked |-> drive_amplitude == 7'h00;
    endproperty
    a_locked_null: assert property (p_locked_null) else $error("drive while locked");
    property p_rt_follow;
        (s_reg.mode == `HD_MODE_RT && s_next.drv_en && $stable(s_reg.mode))
        |=> drive_amplitude == s_reg.rt_level[6:0] || $changed(s_reg.rt_level);
    endproperty
    a_rt_follow: assert property (p_rt_follow) else $error("realtime level not driven");
    property p_unlock_clears;
        (reg_wr && reg_addr == `HD_OFS_CTRL && reg_wdata[`HD_CTRL_UNLOCK_BIT] && det == '0)
        |=> !fault_locked;
    endproperty
    a_unlock_clears: assert property (p_unlock_clears) else $error("unlock failed");
    property p_pwm_idle;
        (s_reg.mode == `HD_MODE_PIN_PULSE_WIDTH_MODE && s_reg.idle_cnt >= PWM_W'(IDLE_CYC) && !reg_wr &&
         multipurpose_pin == s_reg.pin_d) |-> ##2 drive_amplitude == 7'h00;
    endproperty
    a_pwm_idle: assert property (p_pwm_idle) else $error("idle pwm not nulled");
endmodule

`default_nettype wire

/* File: core/haptic_consts.svh */
// constants for the haptic driver control block: offsets, field positions, mode codes, timing
// assumes a 10 MHz core clock and a byte-wide register port
`ifndef HAPTIC_CONSTS_SVH
`define HAPTIC_CONSTS_SVH
`define HD_CLK_HZ             10000000
`define HD_OFS_CTRL           8'h10
`define HD_OFS_MODE           8'h11
`define HD_OFS_TMO            8'h12
`define HD_OFS_STATUS         8'h13
`define HD_OFS_RT_LEVEL       8'h14
`define HD_OFS_OD_LEVEL       8'h15
`define HD_OFS_ACT_LEVEL      8'h16
`define HD_OFS_BRK_LEVEL      8'h17
`define HD_OFS_OD_TIME        8'h18
`define HD_OFS_ACT_TIME       8'h19
`define HD_OFS_BRK_TIME       8'h1a
`define HD_OFS_PAT_START      8'h1b
`define HD_OFS_MEM_PTR        8'h40
`define HD_OFS_MEM_HIGH       8'h41
`define HD_OFS_MEM_MID        8'h42
`define HD_OFS_MEM_LOW        8'h43
`define HD_CTRL_CLKEN_BIT     0
`define HD_CTRL_OCDIS_BIT     1
`define HD_CTRL_THDIS_BIT     2
`define HD_CTRL_UNLOCK_BIT    3
`define HD_CTRL_SWTRIG_BIT    4
`define HD_CTRL_MEMEN_BIT     5
`define HD_MODE_RESET         5'h00
`define HD_MODE_PIN_PULSE_WIDTH_MODE          5'h01
`define HD_MODE_RT            5'h02
`define HD_MODE_EDGE_TRIGGER_MODE          5'h03
`define HD_MODE_RAM           5'h04
`define HD_TMO_UNIT_MS        1000
`define HD_PWM_IDLE_US        2560
`define HD_STEP_MS            5
`define HD_EDGE_TRIGGER_MODE_UNIT_MS       5
`define HD_DUTY_LO_PERMIL     475
`define HD_DUTY_HI_PERMIL     525
`endif

/* File: core/haptic_pkg.sv */
// types shared by the haptic driver control block
// assumes haptic_consts.svh supplies the numbers
package haptic_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_OVERDRIVE, SEQ_ACTIVE, SEQ_BRAKE,
        SEQ_FETCH, SEQ_HOLD, SEQ_GAP
    } seq_state_t;

    typedef struct packed {
        logic [1:0] sample_control;
        logic       sample_polarity;
        logic [6:0] amp;
        logic [4:0] hold;
        logic [4:0] gap;
        logic [3:0] repeat_count;
    } sample_t;

    typedef struct packed {
        logic       fault_supply;
        logic       fault_overcurrent;
        logic       fault_thermal;
        logic       fault_timeout;
    } fault_t;

    // register state of the control block apart from pattern memory and reset sync; pwm counters match PWM_W of the module
    typedef struct packed {
        logic [7:0]  rdata;
        logic        clk_en, oc_dis, th_dis, sw_trig, mem_en;
        logic [4:0]  mode;
        logic [5:0]  tmo;
        logic [7:0]  rt_level, od_level, act_level, brk_level;
        logic [7:0]  od_time, act_time, brk_time, pat_start, mem_ptr;
        logic [23:0] wbuf;
        logic        locked;
        fault_t      faults;
        logic [31:0] vib_cnt;
        logic [5:0]  vib_sec;
        logic        pin_d, trig_d;
        logic [15:0] hi_cnt, per_cnt, idle_cnt;
        logic        pwm_valid;
        logic [7:0]  pwm_level;
        seq_state_t  st;
        logic [31:0] tcnt;
        logic [7:0]  ptr;
        logic [3:0]  rep, prep;
        sample_t     smp;
        logic        drv_en;
        logic [7:0]  drv_level;
    } state_t;
endpackage

/* File: tb/host_pin_model.sv */
// host side of the multipurpose pin: pwm source or a held trigger level
// assumes the block clock; a period of zero holds the static level
`timescale 1ns/100ps
`default_nettype none
module host_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] period,
    input  wire logic [7:0] high_cyc,
    input  wire logic       level,
    output logic            pin
);
    logic [7:0] cnt_reg = 8'h00;
    initial pin = 1'b0;
    always @(posedge clk) begin
        cnt_reg <= (cnt_reg + 8'h01 >= period) ? 8'h00 : cnt_reg + 8'h01;
        // a static level stays put for many clocks so an edge always registers
        pin <= (period == 8'h00) ? level : (cnt_reg < high_cyc);
    end
endmodule
`default_nettype wire

/* File: tb/test_haptic_driver_control.sv */
// self-checking bench for the haptic driver control block
// assumes the host pin model and shortened counts: 100 cycles a second, 4 a step
`timescale 1ns/100ps
`default_nettype none
`include "haptic_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_haptic_driver_control;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       pin;
    logic [3:0] flt = 4'h0;
    logic [7:0] period = 8'h00;
    logic [7:0] high_cyc = 8'h00;
    logic       level = 1'b0;
    logic       driver_enable;
    logic [6:0] drive_amplitude;
    logic       drive_negative;
    logic       fault_locked;
    logic [7:0] st [4] = '{8'h18, 8'h14, 8'h14, 8'h12};
    logic [7:0] hi [4] = '{8'h0f, 8'h05, 8'h0a, 8'h0f};
    logic [1:0] pw [4] = '{2'h1, 2'h3, 2'h0, 2'h1};
    int         error_cnt = 0;
    int         n_tests = 0;
    int         cycles = 0;
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            finish_test();
        end
    end
    host_pin_model host (.clk(clk), .period(period), .high_cyc(high_cyc), .level(level),
        .pin(pin));
    haptic_driver_control #(.TMO_UNIT_CYC(100), .STEP_CYC(4), .IDLE_CYC(50)) uut (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .multipurpose_pin(pin),
        .supply_below_cutoff(flt[0]), .positive_leg_overcurrent_flag(flt[1]),
        .negative_leg_overcurrent_flag(flt[2]), .overtemp_flag(flt[3]),
        .driver_enable(driver_enable), .drive_amplitude(drive_amplitude),
        .drive_negative(drive_negative), .fault_locked(fault_locked));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(reg_rdata, e)
    endtask
    // pwm compares only {negative, nonzero}: the exact duty scaling is not pinned down
    task automatic wait_out(input logic [8:0] e, input int lim, input logic pwm);
        logic [8:0] o;
        o = 9'h000;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            o = pwm ? {7'h00, drive_negative, |drive_amplitude}
                    : {fault_locked, drive_negative, drive_amplitude};
            if (o === e) break;
        end
        `CHK(o, e)
    endtask
    task automatic finish_test();
        $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        wr(`HD_OFS_RT_LEVEL, 8'h85);
        rchk(`HD_OFS_RT_LEVEL, 8'h85);
        rchk(8'h7f, 8'h00);
        wr(`HD_OFS_CTRL, 8'h01);
        wr(`HD_OFS_RT_LEVEL, 8'h05);
        wr(`HD_OFS_MODE, {3'h0, `HD_MODE_RT});
        wait_out(9'h005, 10, 1'b0);
        `CHK(driver_enable, 1'b1)
        wr(`HD_OFS_RT_LEVEL, 8'h85);
        wait_out(9'h085, 10, 1'b0);
        wr(`HD_OFS_RT_LEVEL, 8'h05);
        wait_out(9'h005, 10, 1'b0);
        $display("test realtime done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            flt <= 4'h1 << i;
            wait_out(9'h100, 10, 1'b0);
            rchk(`HD_OFS_STATUS, st[i]);
            @(posedge clk);
            flt <= 4'h0;
            wr(`HD_OFS_CTRL, 8'h09);
            rchk(`HD_OFS_STATUS, 8'h00);
            rchk(`HD_OFS_CTRL, 8'h01);
        end
        for (int j = 0; j < 2; j++) begin
            wr(`HD_OFS_CTRL, j ? 8'h05 : 8'h03);
            @(posedge clk);
            flt <= j ? 4'h8 : 4'h2;
            repeat (20) @(posedge clk);
            #1;
            `CHK(fault_locked, 1'b0)
            @(posedge clk);
            flt <= 4'h0;
        end
        wr(`HD_OFS_CTRL, 8'h01);
        $display("test faults done");
        wr(`HD_OFS_MODE, 8'h00);
        wr(`HD_OFS_TMO, 8'h01);
        wr(`HD_OFS_MODE, {3'h0, `HD_MODE_RT});
        repeat (80) @(posedge clk);
        #1;
        `CHK(fault_locked, 1'b0)
        wait_out(9'h100, 60, 1'b0);
        rchk(`HD_OFS_STATUS, 8'h11);
        wr(`HD_OFS_TMO, 8'h00);
        wr(`HD_OFS_CTRL, 8'h09);
        repeat (300) @(posedge clk);
        #1;
        `CHK(fault_locked, 1'b0)
        $display("test timeout done");
        wr(`HD_OFS_MODE, 8'h00);
        wr(`HD_OFS_OD_LEVEL, 8'h10);
        wr(`HD_OFS_ACT_LEVEL, 8'h20);
        wr(`HD_OFS_BRK_LEVEL, 8'h90);
        wr(`HD_OFS_OD_TIME, 8'h01);
        wr(`HD_OFS_ACT_TIME, 8'h02);
        wr(`HD_OFS_BRK_TIME, 8'h01);
        wr(`HD_OFS_MODE, {3'h0, `HD_MODE_EDGE_TRIGGER_MODE});
        @(posedge clk);
        level <= 1'b1;
        wait_out(9'h010, 20, 1'b0);
        wait_out(9'h020, 20, 1'b0);
        repeat (40) @(posedge clk);
        #1;
        `CHK({fault_locked, drive_negative, drive_amplitude}, 9'h020)
        @(posedge clk);
        level <= 1'b0;
        wait_out(9'h090, 20, 1'b0);
        wait_out(9'h000, 20, 1'b0);
        wr(`HD_OFS_CTRL, 8'h11);
        wait_out(9'h010, 20, 1'b0);
        wr(`HD_OFS_CTRL, 8'h01);
        wait_out(9'h000, 60, 1'b0);
        $display("test edge trigger done");
        wr(`HD_OFS_MODE, 8'h00);
        wr(`HD_OFS_CTRL, 8'h21);
        wr(`HD_OFS_MEM_PTR, 8'h20);
        wr(`HD_OFS_MEM_HIGH, 8'h09);
        wr(`HD_OFS_MEM_MID, 8'h42);
        wr(`HD_OFS_MEM_LOW, 8'h30);
        wr(`HD_OFS_MEM_PTR, 8'h20);
        rchk(`HD_OFS_MEM_HIGH, 8'h09);
        rchk(`HD_OFS_MEM_MID, 8'h42);
        rchk(`HD_OFS_MEM_LOW, 8'h30);
        wr(`HD_OFS_PAT_START, 8'h20);
        wr(`HD_OFS_MODE, {3'h0, `HD_MODE_RAM});
        wr(`HD_OFS_CTRL, 8'h31);
        wait_out(9'h025, 30, 1'b0);
        wr(`HD_OFS_CTRL, 8'h01);
        wait_out(9'h000, 40, 1'b0);
        $display("test stored pattern done");
        wr(`HD_OFS_MODE, {3'h0, `HD_MODE_PIN_PULSE_WIDTH_MODE});
        @(posedge clk);
        period <= 8'h14;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            high_cyc <= hi[k];
            wait_out({7'h00, pw[k]}, 120, 1'b1);
        end
        @(posedge clk);
        period <= 8'h00;
        level <= 1'b1;
        wait_out(9'h000, 120, 1'b1);
        $display("test pwm done");
        wr(`HD_OFS_MODE, 8'h00);
        wr(`HD_OFS_CTRL, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
